//--- rtl/pcx_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz core clock
// Notes:   Definitions only
`ifndef PCX_MAP_SVH
`define PCX_MAP_SVH

// ----------------------------------------------------------------
// Power control register
// ----------------------------------------------------------------
`define PCX_PWR_CTL_ADDR     8'h87
`define PCX_PWR_CTL_RESET    8'h00
`define PCX_BIT_IDLE         0
`define PCX_BIT_GF_LO        2
`define PCX_BIT_GF_HI        3
`define PCX_BIT_BAUD_DOUBLE  7
`define PCX_PWR_CTL_WMASK    8'h8d

// ----------------------------------------------------------------
// Wake filter timing
// ----------------------------------------------------------------
`define PCX_CLK_HZ           50000000
`define PCX_WAKE_MIN_US      400
`define PCX_WAKE_MIN_CYC     ((`PCX_CLK_HZ / 1000000) * `PCX_WAKE_MIN_US)

// ----------------------------------------------------------------
// External data space map
// ----------------------------------------------------------------
`define PCX_XD_RAM_LO        16'hfd80
`define PCX_XD_RAM_HI        16'hff7f
`define PCX_XD_BUF_HI        16'hfeef
`define PCX_XD_OEP0_LO       16'hfef0
`define PCX_XD_OEP0_HI       16'hfef7
`define PCX_XD_IEP0_LO       16'hfef8
`define PCX_XD_IEP0_HI       16'hfeff
`define PCX_XD_SETUP_LO      16'hff00
`define PCX_XD_SETUP_HI      16'hff07
`define PCX_XD_EDB_LO        16'hff08
`define PCX_XD_REG_LO        16'hff80
`define PCX_XD_RAM_BYTES     512

`endif

//--- rtl/pcx_pkg.sv
// Purpose: Types for the power control and data map block
// Assumes: Constants come from pcx_map.svh
// Notes:   Region codes for the external data decode
package pcx_pkg;

    // ------------------------------------------------------------
    // Decoded region of the external data space
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PCX_RGN_NONE,
        PCX_RGN_DATA_BUF,
        PCX_RGN_OUT_EP0,
        PCX_RGN_IN_EP0,
        PCX_RGN_SETUP,
        PCX_RGN_DESC,
        PCX_RGN_MAPPED_REG
    } pcx_region_e;

    // ------------------------------------------------------------
    // Wake filter states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PCX_WK_RUN,
        PCX_WK_IDLE,
        PCX_WK_QUAL
    } pcx_wake_e;

endpackage : pcx_pkg

//--- rtl/pcx_wake_filter.sv
// Purpose: Qualifies the wake line; only a long enough assertion counts
// Assumes: i_wake_active already synchronised, high means asserted
// Notes:   o_wake_pulse is one cycle when the minimum hold time is met
`include "pcx_map.svh"

module pcx_wake_filter #(
    parameter int unsigned MIN_CYC = `PCX_WAKE_MIN_CYC
)(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Control
    input  wire logic i_armed,
    input  wire logic i_wake_active,
    // Result
    output logic      o_wake_pulse
);

    // ------------------------------------------------------------
    // Hold counter
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(MIN_CYC + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          hit;
    pcx_pkg::pcx_wake_e st_reg;
    pcx_pkg::pcx_wake_e st_next;

    // Short pulses restart the count, so they never reach the limit
    assign hit = (cnt_reg == CW'(MIN_CYC - 1));

    always_comb
    begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            pcx_pkg::PCX_WK_RUN:
            begin
                cnt_next = '0;
                if (i_armed)
                    st_next = pcx_pkg::PCX_WK_IDLE;
            end
            pcx_pkg::PCX_WK_IDLE:
            begin
                cnt_next = '0;
                if (!i_armed)
                    st_next = pcx_pkg::PCX_WK_RUN;
                else if (i_wake_active)
                    st_next = pcx_pkg::PCX_WK_QUAL;
            end
            pcx_pkg::PCX_WK_QUAL:
            begin
                if (!i_wake_active || !i_armed)
                begin
                    cnt_next = '0;
                    st_next  = i_armed ? pcx_pkg::PCX_WK_IDLE : pcx_pkg::PCX_WK_RUN;
                end
                else if (hit)
                begin
                    cnt_next = '0;
                    st_next  = pcx_pkg::PCX_WK_RUN;
                end
                else
                    cnt_next = cnt_reg + CW'(1);
            end
            default:
            begin
                st_next  = pcx_pkg::PCX_WK_RUN;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            st_reg       <= pcx_pkg::PCX_WK_RUN;
            cnt_reg      <= '0;
            o_wake_pulse <= 1'b0;
        end
        else
        begin
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            o_wake_pulse <= (st_reg == pcx_pkg::PCX_WK_QUAL) && i_wake_active
                            && i_armed && hit;
        end
    end

endmodule // pcx_wake_filter

//--- rtl/pcx_power_ctl.sv
// Purpose: Power control register and external data space decode
// Assumes: Core special-function-register bus on the core clock
// Notes:   Wake line arrives from a pin and is synchronised here
`include "pcx_map.svh"

module pcx_power_ctl #(
    parameter int unsigned WAKE_MIN_CYC = `PCX_WAKE_MIN_CYC
)(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Special function register bus
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic [7:0]       o_sfr_rdata,
    output logic             o_sfr_hit,
    // Wake line, active low pin
    input  wire logic        i_wake_interrupt_line_n,
    // Power and clock controls
    output logic             o_idle_request,
    output logic             o_ram_low_power,
    output logic             o_osc_pll_stop,
    output logic             o_watchdog_suspend,
    output logic             o_core_run,
    output logic             o_wake_irq,
    output logic             o_baud_double,
    output logic [1:0]       o_general_flags,
    // External data space decode
    input  wire logic [15:0] i_xd_addr,
    output logic             o_xd_reserved,
    output logic             o_xd_ram_sel,
    output logic [8:0]       o_xd_ram_index,
    output logic             o_xd_reg_sel,
    output logic [6:0]       o_xd_reg_index,
    output pcx_pkg::pcx_region_e o_xd_region
);

    // ------------------------------------------------------------
    // Wake line synchroniser
    // ------------------------------------------------------------
    logic wake_meta_reg;
    logic wake_sync_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            wake_meta_reg <= 1'b1;
            wake_sync_reg <= 1'b1;
        end
        else
        begin
            wake_meta_reg <= i_wake_interrupt_line_n;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Power control register
    // ------------------------------------------------------------
    logic       idle_reg;
    logic       idle_next;
    logic [1:0] flags_reg;
    logic       baud_reg;
    logic       wake_pulse;
    logic       pc_sel;
    logic       pc_wr;
    logic [7:0] pc_read;

    assign pc_sel = (i_sfr_addr == `PCX_PWR_CTL_ADDR);
    assign pc_wr  = pc_sel && i_sfr_wr;

    // Wake clear and a write of one can meet; the set is kept so it is not lost
    assign idle_next = (pc_wr && i_sfr_wdata[`PCX_BIT_IDLE]) ? 1'b1 :
                       wake_pulse                            ? 1'b0 :
                       idle_reg;

    // Reserved bits are never stored, so they read as zero
    assign pc_read = {baud_reg, 3'h0, flags_reg, 1'h0, idle_reg};

    pcx_wake_filter #(
        .MIN_CYC       (WAKE_MIN_CYC)
    ) u_wake (
        .i_clk         (i_clk),
        .i_rstn        (i_rstn),
        .i_armed       (idle_reg),
        .i_wake_active (~wake_sync_reg),
        .o_wake_pulse  (wake_pulse)
    );

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            idle_reg  <= 1'(`PCX_PWR_CTL_RESET >> `PCX_BIT_IDLE);
            flags_reg <= 2'h0;
            baud_reg  <= 1'b0;
        end
        else
        begin
            idle_reg <= idle_next;
            if (pc_wr)
            begin
                flags_reg <= i_sfr_wdata[`PCX_BIT_GF_HI:`PCX_BIT_GF_LO];
                baud_reg  <= i_sfr_wdata[`PCX_BIT_BAUD_DOUBLE];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus read and power outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_sfr_rdata        <= 8'h00;
            o_sfr_hit          <= 1'b0;
            o_idle_request     <= 1'b0;
            o_ram_low_power    <= 1'b0;
            o_osc_pll_stop     <= 1'b0;
            o_watchdog_suspend <= 1'b0;
            o_core_run         <= 1'b1;
            o_wake_irq         <= 1'b0;
            o_baud_double      <= 1'b0;
            o_general_flags    <= 2'h0;
        end
        else
        begin
            o_sfr_rdata        <= (pc_sel && i_sfr_rd) ? pc_read : 8'h00;
            o_sfr_hit          <= pc_sel && (i_sfr_rd || i_sfr_wr);
            o_idle_request     <= idle_next;
            o_ram_low_power    <= idle_next;
            o_osc_pll_stop     <= idle_next;
            o_watchdog_suspend <= idle_next;
            o_core_run         <= ~idle_next;
            o_wake_irq         <= wake_pulse && !idle_next;
            o_baud_double      <= pc_wr ? i_sfr_wdata[`PCX_BIT_BAUD_DOUBLE] : baud_reg;
            o_general_flags    <= pc_wr ? i_sfr_wdata[`PCX_BIT_GF_HI:`PCX_BIT_GF_LO]
                                        : flags_reg;
        end
    end

    // ------------------------------------------------------------
    // External data space decode
    // ------------------------------------------------------------
    logic                 in_rsv;
    logic                 in_ram;
    logic                 in_reg;
    logic [15:0]          ram_off;
    pcx_pkg::pcx_region_e rgn;

    assign in_rsv  = (i_xd_addr >= `PCX_XD_RAM_LO);
    assign in_reg  = (i_xd_addr >= `PCX_XD_REG_LO);
    assign in_ram  = in_rsv && (i_xd_addr <= `PCX_XD_RAM_HI);
    assign ram_off = i_xd_addr - `PCX_XD_RAM_LO;

    assign rgn = in_reg                            ? pcx_pkg::PCX_RGN_MAPPED_REG :
                 !in_rsv                           ? pcx_pkg::PCX_RGN_NONE :
                 (i_xd_addr >= `PCX_XD_EDB_LO)     ? pcx_pkg::PCX_RGN_DESC :
                 (i_xd_addr >= `PCX_XD_SETUP_LO)   ? pcx_pkg::PCX_RGN_SETUP :
                 (i_xd_addr >= `PCX_XD_IEP0_LO)    ? pcx_pkg::PCX_RGN_IN_EP0 :
                 (i_xd_addr >= `PCX_XD_OEP0_LO)    ? pcx_pkg::PCX_RGN_OUT_EP0 :
                 pcx_pkg::PCX_RGN_DATA_BUF;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_xd_reserved  <= 1'b0;
            o_xd_ram_sel   <= 1'b0;
            o_xd_ram_index <= 9'h000;
            o_xd_reg_sel   <= 1'b0;
            o_xd_reg_index <= 7'h00;
            o_xd_region    <= pcx_pkg::PCX_RGN_NONE;
        end
        else
        begin
            o_xd_reserved  <= in_rsv;
            o_xd_ram_sel   <= in_ram;
            o_xd_ram_index <= in_ram ? ram_off[8:0] : 9'h000;
            o_xd_reg_sel   <= in_reg;
            o_xd_reg_index <= in_reg ? i_xd_addr[6:0] : 7'h00;
            o_xd_region    <= rgn;
        end
    end

endmodule // pcx_power_ctl

//--- bench/pcx_power_ctl_sva.sv
// Purpose: Assertions on the power control and data map ports
// Assumes: Bound onto pcx_power_ctl, one clock domain
// Notes:   Low count restarts on a core idle write so re-arming is allowed
module pcx_power_ctl_sva #(
    parameter int unsigned WAKE_MIN_CYC = 20000
)(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic        i_sfr_wr,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        o_sfr_hit,
    input wire logic        i_wake_interrupt_line_n,
    input wire logic        o_idle_request,
    input wire logic        o_ram_low_power,
    input wire logic        o_osc_pll_stop,
    input wire logic        o_watchdog_suspend,
    input wire logic        o_core_run,
    input wire logic        o_wake_irq,
    input wire logic        o_baud_double,
    input wire logic [1:0]  o_general_flags,
    input wire logic [15:0] i_xd_addr,
    input wire logic        o_xd_reserved,
    input wire logic        o_xd_reg_sel,
    input wire logic [6:0]  o_xd_reg_index
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Helper count of consecutive low samples on the wake pin
    // ------------------------------------------------------------
    logic [31:0] low_cnt;
    wire         idle_wr = i_sfr_wr && i_sfr_addr == 8'h87 && i_sfr_wdata[0];

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_wake_interrupt_line_n || idle_wr)
            low_cnt <= 32'h0;
        else if (low_cnt != 32'hffffffff)
            low_cnt <= low_cnt + 32'h1;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_idle_set;
        idle_wr;
    endsequence
    sequence s_rd_hit;
        i_sfr_rd && i_sfr_addr == 8'h87;
    endsequence

    idle_copies_a: assert property (
        o_ram_low_power == o_idle_request && o_osc_pll_stop == o_idle_request
        && o_watchdog_suspend == o_idle_request && o_core_run == !o_idle_request)
        else $error("power controls disagree with idle bit");
    idle_set_a: assert property (s_idle_set |=> o_idle_request)
        else $error("idle write did not set idle bit");
    idle_clear_a: assert property (
        $past(i_rstn) && $fell(o_idle_request) |-> o_wake_irq)
        else $error("idle bit cleared without wake");
    irq_cause_a: assert property (
        o_wake_irq |-> $past(o_idle_request) && !o_idle_request)
        else $error("wake interrupt without idle exit");
    wake_min_a: assert property (o_wake_irq |-> low_cnt >= WAKE_MIN_CYC)
        else $error("wake accepted before minimum hold");
    wake_bound_a: assert property (
        low_cnt == WAKE_MIN_CYC + 8 |-> !o_idle_request)
        else $error("long wake did not end idle");
    read_data_a: assert property (s_rd_hit |=> o_sfr_hit && o_sfr_rdata ==
        {$past(o_baud_double), 3'h0, $past(o_general_flags), 1'h0, $past(o_idle_request)})
        else $error("register read data wrong");
    miss_a: assert property (
        (i_sfr_rd || i_sfr_wr) && i_sfr_addr != 8'h87 |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("other address answered");
    fields_a: assert property (i_sfr_wr && i_sfr_addr == 8'h87 |=>
        o_baud_double == $past(i_sfr_wdata[7]) && o_general_flags == $past(i_sfr_wdata[3:2]))
        else $error("baud or flag bits not written");
    decode_a: assert property ($past(i_rstn) |->
        o_xd_reserved == ($past(i_xd_addr) >= 16'hfd80)
        && o_xd_reg_sel == ($past(i_xd_addr) >= 16'hff80)
        && o_xd_reg_index == (o_xd_reg_sel ? $past(i_xd_addr[6:0]) : 7'h00))
        else $error("data space decode wrong");
endmodule // pcx_power_ctl_sva

//--- bench/pcx_core_model.sv
// Purpose: Core side model driving the wake pin
// Assumes: Pin is pulled high when nobody pulls it low
// Notes:   Pulse length in cycles is chosen by the bench
module pcx_core_model (
    input  wire logic i_clk,
    output logic      o_wake_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_wake_n = 1'b1;

    task automatic pulse(input int cycles);
        @(negedge i_clk);
        o_wake_n = 1'b0;
        repeat (cycles) @(negedge i_clk);
        o_wake_n = 1'b1; // Released pin returns to its pull-up level
    endtask
endmodule // pcx_core_model

//--- bench/testbench.sv
// Purpose: Self-checking bench for the power control and data map block
// Assumes: Short wake hold so idle exits stay quick
// Notes:   Random register and address traffic from a fixed seed
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WAKE_MIN_CYC = 8;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, reg_m;
    logic [15:0] i_xd_addr = 16'h0000;
    logic [31:0] seed = 32'hc9ee8e7b;
    logic wake_n, o_sfr_hit, o_idle_request, o_ram_low_power, o_osc_pll_stop;
    logic o_watchdog_suspend, o_core_run, o_wake_irq, o_baud_double, o_xd_reserved;
    logic o_xd_ram_sel, o_xd_reg_sel;
    logic [1:0] o_general_flags;
    logic [8:0] o_xd_ram_index;
    logic [6:0] o_xd_reg_index;
    pcx_pkg::pcx_region_e o_xd_region;
    int bad_count = 0, comparisons = 0, cycles = 0;
    logic [15:0] corners [14] = '{16'h0000, 16'hfd7f, 16'hfd80, 16'hfeef, 16'hfef0,
        16'hfef7, 16'hfef8, 16'hfeff, 16'hff00, 16'hff07, 16'hff08, 16'hff7f,
        16'hff80, 16'hffff};

    pcx_power_ctl #(.WAKE_MIN_CYC(WAKE_MIN_CYC)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
        .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
        .i_wake_interrupt_line_n(wake_n), .o_idle_request(o_idle_request),
        .o_ram_low_power(o_ram_low_power), .o_osc_pll_stop(o_osc_pll_stop),
        .o_watchdog_suspend(o_watchdog_suspend), .o_core_run(o_core_run),
        .o_wake_irq(o_wake_irq), .o_baud_double(o_baud_double),
        .o_general_flags(o_general_flags), .i_xd_addr(i_xd_addr),
        .o_xd_reserved(o_xd_reserved), .o_xd_ram_sel(o_xd_ram_sel),
        .o_xd_ram_index(o_xd_ram_index), .o_xd_reg_sel(o_xd_reg_sel),
        .o_xd_reg_index(o_xd_reg_index), .o_xd_region(o_xd_region));
    pcx_core_model core (.i_clk(i_clk), .o_wake_n(wake_n));

    always #10 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic pcx_pkg::pcx_region_e region(input logic [15:0] a);
        if (a < 16'hfd80) return pcx_pkg::PCX_RGN_NONE;
        if (a <= 16'hfeef) return pcx_pkg::PCX_RGN_DATA_BUF;
        if (a <= 16'hfef7) return pcx_pkg::PCX_RGN_OUT_EP0;
        if (a <= 16'hfeff) return pcx_pkg::PCX_RGN_IN_EP0;
        if (a <= 16'hff07) return pcx_pkg::PCX_RGN_SETUP;
        if (a <= 16'hff7f) return pcx_pkg::PCX_RGN_DESC;
        return pcx_pkg::PCX_RGN_MAPPED_REG;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One bus cycle; read data stands in the cycle after the strobe
    task automatic special_function_register(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_clk);
        i_sfr_wr = wr;
        i_sfr_rd = !wr;
        i_sfr_addr = addr;
        i_sfr_wdata = data;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
        i_sfr_rd = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        special_function_register(1'b0, addr, 8'h00);
        check("sfr read", {7'h0, o_sfr_hit, o_sfr_rdata}, {7'h0, addr == 8'h87, exp});
    endtask

    task automatic wake(input int len, input logic fires);
        int n;
        logic e;
        n = 0;
        e = reg_m[0] & !fires;
        fork
            core.pulse(len);
            repeat (len + 12)
            begin
                @(negedge i_clk);
                if (o_wake_irq === 1'b1) n++;
            end
        join
        check("wake irq count", 16'(n), {15'h0, fires});
        check("idle outputs", {12'h0, o_idle_request, o_ram_low_power, o_osc_pll_stop,
            o_watchdog_suspend}, {12'h0, {4{e}}});
        check("core run", {15'h0, o_core_run}, {15'h0, !e});
        reg_m[0] = e;
    endtask

    task automatic xd(input logic [15:0] a);
        logic ram;
        @(negedge i_clk);
        i_xd_addr = a;
        @(negedge i_clk);
        ram = a >= 16'hfd80 && a <= 16'hff7f;
        check("xd region", {13'h0, o_xd_region}, {13'h0, region(a)});
        check("xd ram", {6'h0, o_xd_ram_sel, o_xd_ram_index},
            {6'h0, ram, ram ? 9'(a - 16'hfd80) : 9'h000});
        check("xd reg", {7'h0, o_xd_reserved, o_xd_reg_sel, o_xd_reg_index}, {7'h0,
            a >= 16'hfd80, a >= 16'hff80, a >= 16'hff80 ? a[6:0] : 7'h00});
    endtask

    // Hang guard, well beyond the roughly 760 cycles the run needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end

    initial
    begin
        repeat (10) @(negedge i_clk);
        i_rstn = 1'b1;
        reg_m = 8'h00;
        check("core run at reset", {15'h0, o_core_run}, 16'h0001);
        rd_chk(8'h87, 8'h00);
        special_function_register(1'b1, 8'h87, 8'hff);
        reg_m = 8'h8d;
        rd_chk(8'h87, 8'h8d);
        special_function_register(1'b1, 8'h87, 8'h00);
        reg_m = 8'h01;
        rd_chk(8'h87, 8'h01);
        wake(WAKE_MIN_CYC - 1, 1'b0);
        wake(20, 1'b1);
        wake(20, 1'b0);
        for (int i = 0; i < 60; i++)
        begin
            seed = lfsr(seed);
            special_function_register(1'b1, 8'h87, seed[7:0]);
            reg_m = (reg_m & 8'h01) | (seed[7:0] & 8'h8d);
            special_function_register(1'b1, seed[15:8] == 8'h87 ? 8'h86 : seed[15:8], ~seed[7:0]);
            rd_chk(seed[15:8] == 8'h87 ? 8'h86 : seed[15:8], 8'h00);
            rd_chk(8'h87, reg_m);
            check("ctl outputs", {12'h0, o_baud_double, o_general_flags, o_idle_request},
                {12'h0, reg_m[7], reg_m[3:2], reg_m[0]});
            xd(seed[31:16]);
        end
        foreach (corners[k]) xd(corners[k]);
        wake(20, reg_m[0]);
        summarize();
    end
endmodule // testbench

bind pcx_power_ctl pcx_power_ctl_sva #(.WAKE_MIN_CYC(WAKE_MIN_CYC)) chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_wake_interrupt_line_n(i_wake_interrupt_line_n),
    .o_idle_request(o_idle_request), .o_ram_low_power(o_ram_low_power),
    .o_osc_pll_stop(o_osc_pll_stop), .o_watchdog_suspend(o_watchdog_suspend),
    .o_core_run(o_core_run), .o_wake_irq(o_wake_irq), .o_baud_double(o_baud_double),
    .o_general_flags(o_general_flags), .i_xd_addr(i_xd_addr),
    .o_xd_reserved(o_xd_reserved), .o_xd_reg_sel(o_xd_reg_sel),
    .o_xd_reg_index(o_xd_reg_index));
